/* design/scl_defs.vh */
`ifndef SCL_DEFS_VH
`define SCL_DEFS_VH
`define SCL_GAP_BASE   16'h000a
`define SCL_GAP_RT     16'h0019
`define SCL_LINE_GAP   16'h0014
`define SCL_DIM_W      16
`define SCL_REP_W      8
`define SCL_DEF_WIDTH  16'h0010
`define SCL_DEF_HEIGHT 16'h0010
`define SCL_DEF_HREP   8'h02
`define SCL_DEF_VREP   8'h02
`define SCL_FIFO_DEPTH 8
`endif

/* design/scl_fifo.v */
`timescale 1ns/1ps
module scl_fifo
#(
   parameter DW    = 26,
   parameter DEPTH = 8
)
(
   input  wire          clk_sys_i,
   input  wire          rst_n_i,
   input  wire [DW-1:0] wr_data_i,
   input  wire          wr_valid_i,
   output wire          wr_ready_o,
   output wire [DW-1:0] rd_data_o,
   output wire          rd_valid_o,
   input  wire          rd_ready_i
);
   localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam LAST_I = DEPTH - 1;
   localparam [AW:0] DEPTH_C = DEPTH[AW:0];
   localparam [AW-1:0] LAST_C = LAST_I[AW-1:0];

   reg [DW-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp_reg;
   reg [AW-1:0] rp_reg;
   reg [AW:0]   cnt_reg;
   reg [DW-1:0] dout_reg;
   reg          vld_reg;

   wire push = wr_valid_i & wr_ready_o;
   // output register refills when empty or once the sink took the held word
   wire load = (cnt_reg != {(AW+1){1'b0}}) & (~vld_reg | rd_ready_i);

   assign wr_ready_o = (cnt_reg != DEPTH_C);
   assign rd_data_o  = dout_reg;
   assign rd_valid_o = vld_reg;

   always @(posedge clk_sys_i)
   begin
      if (push)
      begin
         mem[wp_reg] <= wr_data_i;
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         wp_reg   <= {AW{1'b0}};
         rp_reg   <= {AW{1'b0}};
         cnt_reg  <= {(AW+1){1'b0}};
         dout_reg <= {DW{1'b0}};
         vld_reg  <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wp_reg <= (wp_reg == LAST_C) ? {AW{1'b0}} : wp_reg + 1'b1;
         end
         if (load)
         begin
            dout_reg <= mem[rp_reg];
            vld_reg  <= 1'b1;
            rp_reg   <= (rp_reg == LAST_C) ? {AW{1'b0}} : rp_reg + 1'b1;
         end
         else if (rd_ready_i)
         begin
            vld_reg <= 1'b0;
         end
         cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      end
   end
endmodule

/* design/scl_scaler.v */
`timescale 1ns/1ps
`include "scl_defs.vh"
module scl_scaler
#(
   parameter DW          = 24,
   parameter MAX_W       = 16,
   parameter NV_TAPS     = 4,
   parameter RUNTIME_CTL = 0,
   parameter FIFO_DEPTH  = `SCL_FIFO_DEPTH
)
(
   input  wire                  clk_sys_i,
   input  wire                  rst_n_i,
   input  wire [DW-1:0]         in_data_i,
   input  wire                  in_valid_i,
   input  wire                  in_eop_i,
   output wire                  in_ready_o,
   input  wire                  mode_poly_i,
   input  wire [`SCL_DIM_W-1:0] rt_width_i,
   input  wire [`SCL_DIM_W-1:0] rt_height_i,
   input  wire [`SCL_REP_W-1:0] rt_hrep_i,
   input  wire [`SCL_REP_W-1:0] rt_vrep_i,
   output wire [DW-1:0]         out_data_o,
   output wire                  out_valid_o,
   output wire                  out_sop_o,
   output wire                  out_eop_o,
   input  wire                  out_ready_i
);
   localparam NL = (NV_TAPS > 2) ? NV_TAPS - 1 : 1;
   localparam SW = (NL > 1) ? $clog2(NL) : 1;
   localparam XW = (MAX_W > 1) ? $clog2(MAX_W) : 1;
   localparam NL_M1 = NL - 1;
   localparam [3:0]    NEED_POLY = NL[3:0];
   localparam [SW-1:0] SLOT_LAST = NL_M1[SW-1:0];
   localparam DIM = `SCL_DIM_W;
   localparam REP = `SCL_REP_W;
   localparam [DIM-1:0] GAP_LEN =
      `SCL_GAP_BASE + ((RUNTIME_CTL != 0) ? `SCL_GAP_RT : 16'h0000);
   localparam [DIM-1:0] LGAP_LEN = `SCL_LINE_GAP;

   localparam [4:0] ST_GAP  = 5'h01;
   localparam [4:0] ST_READ = 5'h02;
   localparam [4:0] ST_WR   = 5'h04;
   localparam [4:0] ST_LGAP = 5'h08;
   localparam [4:0] ST_DISC = 5'h10;

   ////////////////////////////////////////////////////////////////////////////
   reg [4:0]     state_reg;
   reg [4:0]     state_next;
   reg           in_ready_reg;
   reg [DIM-1:0] cnt_reg;
   reg [DIM-1:0] cfg_w_reg;
   reg [DIM-1:0] cfg_h_reg;
   reg [REP-1:0] cfg_hr_reg;
   reg [REP-1:0] cfg_vr_reg;
   reg           cfg_poly_reg;
   reg [DIM-1:0] x_in_reg;
   reg [DIM-1:0] y_in_reg;
   reg [DIM-1:0] x_out_reg;
   reg [REP-1:0] h_reg;
   reg [REP-1:0] v_reg;
   reg [3:0]     held_reg;
   reg [SW-1:0]  wr_slot_reg;
   reg [SW-1:0]  rd_slot_reg;
   reg           in_done_reg;
   reg           early_reg;
   reg           disc_pend_reg;
   reg           first_reg;
   reg [DW-1:0]  lbuf [0:(1 << (SW + XW)) - 1];

   wire          f_wr_ready;
   wire [3:0]    need = cfg_poly_reg ? NEED_POLY : 4'h1;
   wire          acc = in_valid_i & in_ready_reg;
   wire          rd_fire = acc & state_reg[1];
   wire          in_line_end =
      rd_fire & (in_eop_i | (x_in_reg == cfg_w_reg - 1'b1));
   wire          last_row = (y_in_reg == cfg_h_reg - 1'b1);
   wire          last_in = in_eop_i | last_row;
   wire          wr_fire = state_reg[2] & f_wr_ready;
   wire          pix_last = (h_reg == cfg_hr_reg - 1'b1);
   wire          row_last = (x_out_reg == cfg_w_reg - 1'b1);
   wire          out_line_end = wr_fire & pix_last & row_last;
   wire          pop = early_reg | (v_reg == cfg_vr_reg - 1'b1);
   wire          last_out =
      early_reg | (in_done_reg & (held_reg == 4'h1) & pop);
   wire [3:0]    held_after = held_reg - {3'h0, pop};
   wire [SW+XW-1:0] wr_addr = {wr_slot_reg, x_in_reg[XW-1:0]};
   wire [SW+XW-1:0] rd_addr = {rd_slot_reg, x_out_reg[XW-1:0]};
   wire [DW+1:0] f_wr_data;
   wire [DW+1:0] f_rd_data;

   assign f_wr_data  = {first_reg, pix_last & row_last & last_out,
                        lbuf[rd_addr]};
   assign in_ready_o = in_ready_reg;
   assign out_data_o = f_rd_data[DW-1:0];
   assign out_eop_o  = f_rd_data[DW];
   assign out_sop_o  = f_rd_data[DW+1];

   function [SW-1:0] slot_inc;
      input [SW-1:0] s;
      begin
         slot_inc = (s == SLOT_LAST) ? {SW{1'b0}} : s + 1'b1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_GAP:
         begin
            if (cnt_reg == GAP_LEN - 1'b1)
            begin
               state_next = ST_READ;
            end
         end
         ST_READ:
         begin
            // input only while a line slot is free
            if (in_line_end &
                (((held_reg + 1'b1) >= need) | last_in))
            begin
               state_next = ST_WR;
            end
         end
         ST_WR:
         begin
            if (out_line_end)
            begin
               if (!last_out)
               begin
                  state_next = ST_LGAP;
               end
               else if (disc_pend_reg)
               begin
                  state_next = ST_DISC;
               end
               else
               begin
                  state_next = ST_GAP;
               end
            end
         end
         ST_LGAP:
         begin
            if (cnt_reg == LGAP_LEN - 1'b1)
            begin
               // drain: once input is done only writes remain
               if (!in_done_reg & (held_reg < need))
               begin
                  state_next = ST_READ;
               end
               else
               begin
                  state_next = ST_WR;
               end
            end
         end
         ST_DISC:
         begin
            if (acc & in_eop_i)
            begin
               state_next = ST_GAP;
            end
         end
         default:
         begin
            state_next = ST_GAP;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys_i)
   begin
      if (rd_fire)
      begin
         lbuf[wr_addr] <= in_data_i;
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         state_reg     <= ST_GAP;
         in_ready_reg  <= 1'b0;
         cnt_reg       <= {DIM{1'b0}};
         cfg_w_reg     <= `SCL_DEF_WIDTH;
         cfg_h_reg     <= `SCL_DEF_HEIGHT;
         cfg_hr_reg    <= `SCL_DEF_HREP;
         cfg_vr_reg    <= `SCL_DEF_VREP;
         cfg_poly_reg  <= 1'b0;
         x_in_reg      <= {DIM{1'b0}};
         y_in_reg      <= {DIM{1'b0}};
         x_out_reg     <= {DIM{1'b0}};
         h_reg         <= {REP{1'b0}};
         v_reg         <= {REP{1'b0}};
         held_reg      <= 4'h0;
         wr_slot_reg   <= {SW{1'b0}};
         rd_slot_reg   <= {SW{1'b0}};
         in_done_reg   <= 1'b0;
         early_reg     <= 1'b0;
         disc_pend_reg <= 1'b0;
         first_reg     <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         // ready follows the next state so no beat slips past a line end
         in_ready_reg <= state_next[1] | state_next[4];
         cnt_reg      <= (state_next != state_reg) ? {DIM{1'b0}}
                                                   : cnt_reg + 1'b1;
         if (state_reg[0] & state_next[1])
         begin
            // resolution is only sampled between frames
            if (RUNTIME_CTL != 0)
            begin
               cfg_w_reg  <= rt_width_i;
               cfg_h_reg  <= rt_height_i;
               cfg_hr_reg <= rt_hrep_i;
               cfg_vr_reg <= rt_vrep_i;
            end
            cfg_poly_reg  <= mode_poly_i;
            x_in_reg      <= {DIM{1'b0}};
            y_in_reg      <= {DIM{1'b0}};
            x_out_reg     <= {DIM{1'b0}};
            h_reg         <= {REP{1'b0}};
            v_reg         <= {REP{1'b0}};
            held_reg      <= 4'h0;
            wr_slot_reg   <= {SW{1'b0}};
            rd_slot_reg   <= {SW{1'b0}};
            in_done_reg   <= 1'b0;
            early_reg     <= 1'b0;
            disc_pend_reg <= 1'b0;
            first_reg     <= 1'b1;
         end
         else
         begin
            if (rd_fire)
            begin
               x_in_reg <= x_in_reg + 1'b1;
            end
            if (in_line_end)
            begin
               x_in_reg      <= {DIM{1'b0}};
               y_in_reg      <= y_in_reg + 1'b1;
               wr_slot_reg   <= slot_inc(wr_slot_reg);
               in_done_reg   <= last_in;
               early_reg     <= in_eop_i & ~last_row;
               disc_pend_reg <= last_row & ~in_eop_i;
            end
            if (wr_fire)
            begin
               first_reg <= 1'b0;
               h_reg     <= pix_last ? {REP{1'b0}} : h_reg + 1'b1;
               if (pix_last)
               begin
                  x_out_reg <= row_last ? {DIM{1'b0}} : x_out_reg + 1'b1;
               end
            end
            if (out_line_end)
            begin
               v_reg <= pop ? {REP{1'b0}} : v_reg + 1'b1;
               if (pop)
               begin
                  rd_slot_reg <= slot_inc(rd_slot_reg);
               end
            end
            held_reg <= (out_line_end ? held_after : held_reg)
                        + {3'h0, in_line_end};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fifo absorbs sink stalls; a full fifo freezes the write state
   scl_fifo
   #(
      .DW    (DW + 2),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .wr_data_i  (f_wr_data),
      .wr_valid_i (state_reg[2]),
      .wr_ready_o (f_wr_ready),
      .rd_data_o  (f_rd_data),
      .rd_valid_o (out_valid_o),
      .rd_ready_i (out_ready_i)
   );
endmodule

/* bench/scl_scaler_props.sv */
`timescale 1ns/1ps
module scl_scaler_props
#(
   parameter DW          = 24,
   parameter NV_TAPS     = 4,
   parameter RUNTIME_CTL = 0
)
(
   input wire          clk_sys_i,
   input wire          rst_n_i,
   input wire          in_valid_i,
   input wire          in_eop_i,
   input wire          in_ready_o,
   input wire          mode_poly_i,
   input wire [15:0]   rt_width_i,
   input wire [DW-1:0] out_data_o,
   input wire          out_valid_o,
   input wire          out_sop_o,
   input wire          out_eop_o,
   input wire          out_ready_i
);
   localparam int LO = RUNTIME_CTL ? 33 : 8;
   localparam int HI = RUNTIME_CTL ? 37 : 12;
   logic [15:0] nin_reg;
   logic [15:0] xin_reg;
   wire         tin  = in_valid_i && in_ready_o;
   wire         tout = out_valid_o && out_ready_i;
   wire         lend = xin_reg == rt_width_i - 16'h0001;
   wire [15:0]  need = mode_poly_i ? 16'(rt_width_i * (NV_TAPS - 1))
                                   : rt_width_i;
   // nin also counts a discarded tail, which only weakens the check
   always @(posedge clk_sys_i)
      if (!rst_n_i || (tout && out_eop_o))
         nin_reg <= 16'h0000;
      else if (tin)
         nin_reg <= nin_reg + 16'h0001;
   always @(posedge clk_sys_i)
      if (!rst_n_i || (tin && (in_eop_i || lend)))
         xin_reg <= 16'h0000;
      else if (tin)
         xin_reg <= xin_reg + 16'h0001;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   chk_data_hold: assert property (out_valid_o && !out_ready_i |=>
      $stable(out_data_o)) else $error("output data moved in stall");
   chk_flag_hold: assert property (out_valid_o && !out_ready_i |=>
      out_valid_o && $stable({out_sop_o, out_eop_o}))
      else $error("output flags moved in stall");
   chk_gap_quiet: assert property ($rose(rst_n_i) |->
      !in_ready_o [*8]) else $error("input ready early after reset");
   chk_gap_end: assert property ($rose(rst_n_i) |->
      ##[LO:HI] in_ready_o) else $error("frame gap length wrong");
   chk_drain_stall: assert property (tin && in_eop_i |=>
      !in_ready_o [*8]) else $error("input read while draining");
   chk_line_stall: assert property (tin && !mode_poly_i && lend |=>
      !in_ready_o) else $error("input ready after a buffered line");
   chk_frame_idle: assert property (tout && out_eop_o |=>
      !out_valid_o [*8]) else $error("output right after frame end");
   chk_first_line: assert property (out_valid_o && out_sop_o |->
      nin_reg >= need) else $error("output before lines buffered");
endmodule

bind scl_scaler scl_scaler_props #(.DW(DW), .NV_TAPS(NV_TAPS),
   .RUNTIME_CTL(RUNTIME_CTL)) u_props (.clk_sys_i(clk_sys_i),
   .rst_n_i(rst_n_i), .in_valid_i(in_valid_i), .in_eop_i(in_eop_i),
   .in_ready_o(in_ready_o), .mode_poly_i(mode_poly_i),
   .rt_width_i(rt_width_i), .out_data_o(out_data_o),
   .out_valid_o(out_valid_o), .out_sop_o(out_sop_o),
   .out_eop_o(out_eop_o), .out_ready_i(out_ready_i));

/* bench/scl_sink_model.sv */
`timescale 1ns/1ps
module scl_sink_model
#(
   parameter DW = 24
)
(
   input  wire          clk_sys_i,
   input  wire          rst_n_i,
   input  wire [1:0]    pace_i,
   input  wire [DW-1:0] data_i,
   input  wire          valid_i,
   input  wire          sop_i,
   input  wire          eop_i,
   output logic         ready_o
);
   logic [1:0]    cyc_reg = 2'h0;
   logic [DW+1:0] beats[$];
   initial ready_o = 1'b0;
   // pace 0 always ready, 1 stalls one cycle in four, 2 holds off
   always @(posedge clk_sys_i)
   begin
      if (rst_n_i && valid_i && ready_o)
         beats.push_back({sop_i, eop_i, data_i});
      cyc_reg <= cyc_reg + 2'h1;
      ready_o <= pace_i == 2'h0 || (pace_i == 2'h1 && cyc_reg != 2'h3);
   end
endmodule

/* bench/scl_scaler_tb.sv */
`timescale 1ns/1ps
module scl_scaler_tb;
   typedef struct packed
   {
      logic        poly;
      logic [15:0] w;
      logic [15:0] h;
      logic [7:0]  hr;
      logic [7:0]  vr;
      logic [15:0] n;
   } scl_row_t;
   logic        clk_sys_i   = 1'b0;
   logic        rst_n_i     = 1'b0;
   logic [23:0] in_data_i   = 24'h000000;
   logic        in_valid_i  = 1'b0;
   logic        in_eop_i    = 1'b0;
   logic        mode_poly_i = 1'b0;
   logic [15:0] rt_width_i  = 16'h0002;
   logic [15:0] rt_height_i = 16'h0002;
   logic [7:0]  rt_hrep_i   = 8'h02;
   logic [7:0]  rt_vrep_i   = 8'h02;
   logic [1:0]  pace        = 2'h0;
   logic [25:0] exp_q[$];
   wire  [23:0] out_data_o;
   wire         in_ready_o;
   wire         out_valid_o;
   wire         out_sop_o;
   wire         out_eop_o;
   wire         out_ready_i;
   int          failures    = 0;
   int          n_compared  = 0;
   scl_row_t    rows[5]     = '{
      '{1'b0, 16'h0002, 16'h0002, 8'h02, 8'h02, 16'h0010},
      '{1'b0, 16'h0010, 16'h0001, 8'h01, 8'h01, 16'h0010},
      '{1'b0, 16'h0001, 16'h0003, 8'h03, 8'h01, 16'h0009},
      '{1'b1, 16'h0002, 16'h0004, 8'h02, 8'h02, 16'h0020},
      '{1'b1, 16'h0003, 16'h0003, 8'h01, 8'h03, 16'h001b}};
   scl_scaler #(.DW(24), .MAX_W(16), .NV_TAPS(4), .RUNTIME_CTL(1),
      .FIFO_DEPTH(8)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .in_data_i(in_data_i), .in_valid_i(in_valid_i), .in_eop_i(in_eop_i),
      .in_ready_o(in_ready_o), .mode_poly_i(mode_poly_i),
      .rt_width_i(rt_width_i), .rt_height_i(rt_height_i),
      .rt_hrep_i(rt_hrep_i), .rt_vrep_i(rt_vrep_i), .out_data_o(out_data_o),
      .out_valid_o(out_valid_o), .out_sop_o(out_sop_o),
      .out_eop_o(out_eop_o), .out_ready_i(out_ready_i));
   scl_sink_model #(.DW(24)) u_sink (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .pace_i(pace), .data_i(out_data_o),
      .valid_i(out_valid_o), .sop_i(out_sop_o), .eop_i(out_eop_o),
      .ready_o(out_ready_i));
   initial
      forever #2.5 clk_sys_i = ~clk_sys_i;
   ////////////////////////////////////////
   task automatic wrap_up;
      $display("compared %0d failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cfg(input scl_row_t r);
      @(negedge clk_sys_i);
      mode_poly_i = r.poly;
      rt_width_i  = r.w;
      rt_height_i = r.h;
      rt_hrep_i   = r.hr;
      rt_vrep_i   = r.vr;
   endtask
   task automatic send(input logic [23:0] d, input logic e);
      logic rdy;
      int   i;
      rdy = 1'b0;
      for (i = 0; i < 4000 && !rdy; i++)
      begin
         @(negedge clk_sys_i);
         in_valid_i = 1'b1;
         in_data_i  = d;
         in_eop_i   = e;
         rdy = in_ready_o;
         @(posedge clk_sys_i);
      end
      if (!rdy)
      begin
         failures++;
         wrap_up();
      end
   endtask
   task automatic frame(input int f, w, ny, input logic e);
      for (int y = 0; y < ny; y++)
         for (int x = 0; x < w; x++)
            send({8'(f), 8'(y), 8'(x)}, e && y == ny - 1 && x == w - 1);
      @(negedge clk_sys_i);
      in_valid_i = 1'b0;
   endtask
   // last input line gets vl output copies, the others vr
   task automatic build(input int f, w, ny, hr, vr, vl);
      exp_q.delete();
      for (int y = 0; y < ny; y++)
         for (int v = 0; v < (y == ny - 1 ? vl : vr); v++)
            for (int x = 0; x < w * hr; x++)
               exp_q.push_back({2'b00, 8'(f), 8'(y), 8'(x / hr)});
      exp_q[0][25] = 1'b1;
      exp_q[$][24] = 1'b1;
   endtask
   task automatic collect(input string what, input int n);
      int i;
      for (i = 0; i < 5000 && u_sink.beats.size() < n; i++)
         @(posedge clk_sys_i);
      check({what, " count"}, u_sink.beats.size(), exp_q.size());
      foreach (exp_q[j])
         check(what, u_sink.beats[j], exp_q[j]);
      u_sink.beats.delete();
      $display("test %s done", what);
      if (i == 5000)
      begin
         failures++;
         wrap_up();
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (2) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      for (int r = 0; r < 5; r++)
      begin
         cfg(rows[r]);
         frame(r, rows[r].w, rows[r].h, 1'b1);
         build(r, rows[r].w, rows[r].h, rows[r].hr, rows[r].vr, rows[r].vr);
         collect("row", rows[r].n);
      end
      cfg('{1'b0, 16'h0004, 16'h0003, 8'h02, 8'h02, 16'h0030});
      pace = 2'h2;
      fork
         frame(5, 4, 3, 1'b1);
      join_none
      repeat (300) @(negedge clk_sys_i);
      check("in_ready_o full", in_ready_o, 1'b0);
      check("out_valid_o held", out_valid_o, 1'b1);
      pace = 2'h1;
      build(5, 4, 3, 2, 2, 2);
      collect("backpressure", 48);
      cfg('{1'b0, 16'h0002, 16'h0003, 8'h02, 8'h02, 16'h0004});
      pace = 2'h0;
      frame(6, 2, 1, 1'b1);
      build(6, 2, 1, 2, 2, 1);
      collect("early eop", 4);
      cfg('{1'b0, 16'h0003, 16'h0002, 8'h01, 8'h01, 16'h0006});
      frame(7, 3, 2, 1'b0);
      frame(8, 2, 1, 1'b1);
      build(7, 3, 2, 1, 1, 1);
      collect("missing eop", 6);
      frame(9, 3, 2, 1'b1);
      build(9, 3, 2, 1, 1, 1);
      collect("after discard", 6);
      frame(10, 3, 2, 1'b1);
      rst_n_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      check("in_ready_o reset", in_ready_o, 1'b0);
      check("out_valid_o reset", out_valid_o, 1'b0);
      rst_n_i = 1'b1;
      u_sink.beats.delete();
      frame(11, 3, 2, 1'b1);
      build(11, 3, 2, 1, 1, 1);
      collect("after reset", 6);
      wrap_up();
   end
endmodule
